// File: core/rre_defines.svh
// Purpose: Constants for the return and rotate executor
// Assumes: One quarter phase per mclk cycle
// Notes:   Offsets are indices on the plain register port
//
// Functional notes
// - Decode 0000 0000 0001 001s as return
// - Return pops stack top into program counter
// - Flag set restores work, flags, bank shadows
// - Flag clear leaves work, flags, bank alone
// - Return keeps both upper counter latches
// - Return with flag clear changes no arithmetic flag
// - Rotate left via carry, update C N Z
// - d=0 writes work, d=1 writes file
// - a=0 access bank, a=1 bank select
// - Rotate left no carry, only N Z
// - Literal return loads work, pops, two cycles
`ifndef RRE_DEFINES_SVH
`define RRE_DEFINES_SVH

// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define RRE_RET_MASK      16'hfffe
`define RRE_RET_PAT       16'h0012
`define RRE_LRET_MASK     16'hff00
`define RRE_LRET_PAT      16'h0c00
`define RRE_RLC_MASK      16'hfc00
`define RRE_RLC_PAT       16'h3400
`define RRE_RLN_PAT       16'h4400
`define RRE_FLD_S         0
`define RRE_FLD_D         9
`define RRE_FLD_A         8

// ----------------------------------------
// Status bits and access bank split
// ----------------------------------------
`define RRE_ST_C          0
`define RRE_ST_Z          2
`define RRE_ST_N          4
`define RRE_ACC_SPLIT     8'h80
`define RRE_ACC_HIBANK    4'hf

// ----------------------------------------
// Register indices
// ----------------------------------------
`define RRE_REG_WORK      4'h0
`define RRE_REG_FLAGS     4'h1
`define RRE_REG_BANK      4'h2
`define RRE_REG_WSHAD     4'h3
`define RRE_REG_FSHAD     4'h4
`define RRE_REG_BSHAD     4'h5
`define RRE_REG_PCHI      4'h6
`define RRE_REG_PCUP      4'h7
`define RRE_REG_PC0       4'h8
`define RRE_REG_PC1       4'h9
`define RRE_REG_PC2       4'ha
`define RRE_REG_SP        4'hb

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RRE_RST_BYTE      8'h00
`define RRE_RST_PC        21'h000000

`endif

// File: core/rre_pkg.sv
// Purpose: Types for the return and rotate executor
// Assumes: Constants live in rre_defines.svh
// Notes:   Binary codes written out
package rre_pkg;

   typedef enum logic [1:0] {
      RRE_Q1 = 2'b00,
      RRE_Q2 = 2'b01,
      RRE_Q3 = 2'b10,
      RRE_Q4 = 2'b11
   } rre_phase_e;

   typedef enum logic [2:0] {
      RRE_OP_NONE = 3'b000,
      RRE_OP_RET  = 3'b001,
      RRE_OP_LRET = 3'b010,
      RRE_OP_RLC  = 3'b011,
      RRE_OP_RLN  = 3'b100,
      RRE_OP_IDLE = 3'b101
   } rre_op_e;

   typedef logic [7:0] rre_byte_t;

endpackage : rre_pkg

// File: core/rre_stack_mem.sv
// Purpose: Return stack storage
// Assumes: One write and one registered read per cycle
// Notes:   Read data come from a register
`timescale 1ns/1ns
module rre_stack_mem #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 31,
   parameter int AW    = 5
) (
   // Clock
   input  wire logic             mclk,
   // Write side
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   // Read side
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);

   logic [WIDTH-1:0] memQ [DEPTH];

   always_ff @(posedge mclk)
   begin
      if (wrEn)
      begin
         memQ[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge mclk)
   begin
      rdData <= memQ[rdAddr];
   end

endmodule : rre_stack_mem

// File: core/rre_core.sv
// Purpose: Executes return, literal return and rotate-left instructions
// Assumes: One mclk cycle per quarter phase; file read data one cycle after fileRd
// Notes:   Execution wins over a register port write in the same cycle
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "rre_defines.svh"
module rre_core #(
   parameter int PCW   = 21,
   parameter int DEPTH = 31,
   parameter int SPW   = 5
) (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_b,
   // Instruction fetch
   input  wire logic [15:0]            instrWord,
   input  wire logic                   instrValid,
   output logic                        instrTake,
   // Call side pushes
   input  wire logic                   pushReq,
   input  wire logic [PCW-1:0]         pushAddr,
   // Program counter load
   output logic      [PCW-1:0]         pcQ,
   output logic                        pcLoad_q,
   // Data register file
   output logic      [11:0]            fileAddr,
   output logic                        fileRd,
   input  wire rre_pkg::rre_byte_t     fileRdData,
   output logic                        fileWr,
   output rre_pkg::rre_byte_t          fileWrData,
   // Register port
   input  wire logic [3:0]             regAddr,
   input  wire rre_pkg::rre_byte_t     regWrData,
   input  wire logic                   regWr,
   input  wire logic                   regRd,
   output rre_pkg::rre_byte_t          regRdData
);
   import rre_pkg::*;

   rre_phase_e       phaseQ;
   rre_op_e          opQ;
   logic [15:0]      instrQ;
   logic             secondQ;
   rre_byte_t        workQ;
   rre_byte_t        flagsQ;
   logic [3:0]       bankQ;
   rre_byte_t        workShadQ;
   rre_byte_t        flagsShadQ;
   logic [3:0]       bankShadQ;
   rre_byte_t        pcHighQ;
   rre_byte_t        pcUpQ;
   logic [SPW-1:0]   spQ;
   rre_byte_t        resultQ;
   logic             carryOutQ;
   logic [PCW-1:0]   stackTop;
   logic [SPW-1:0]   topAddr;
   rre_op_e          opD;
   logic             isRot;
   logic             destFile;
   logic             popNow;

   // ----------------------------------------
   // Quarter phases
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         phaseQ <= RRE_Q1;
      end
      else
      begin
         phaseQ <= rre_phase_e'(phaseQ + 2'b01);
      end
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   always_comb
   begin
      opD = RRE_OP_NONE;
      if ((instrWord & `RRE_RET_MASK) == `RRE_RET_PAT)
      begin
         opD = RRE_OP_RET;
      end
      else if ((instrWord & `RRE_LRET_MASK) == `RRE_LRET_PAT)
      begin
         opD = RRE_OP_LRET;
      end
      else if ((instrWord & `RRE_RLC_MASK) == `RRE_RLC_PAT)
      begin
         opD = RRE_OP_RLC;
      end
      else if ((instrWord & `RRE_RLC_MASK) == `RRE_RLN_PAT)
      begin
         opD = RRE_OP_RLN;
      end
   end

   // Second cycle of a two-cycle op takes no new word
   assign instrTake = (phaseQ == RRE_Q1) && instrValid && !secondQ;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         opQ    <= RRE_OP_IDLE;
         instrQ <= 16'h0000;
      end
      else if (phaseQ == RRE_Q1)
      begin
         if (instrTake)
         begin
            opQ    <= opD;
            instrQ <= instrWord;
         end
         else
         begin
            opQ <= RRE_OP_IDLE;
         end
      end
   end

   // Two-cycle returns: the following cycle is a no-operation
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         secondQ <= 1'b0;
      end
      else if (phaseQ == RRE_Q4)
      begin
         secondQ <= popNow;
      end
   end

   assign isRot    = (opQ == RRE_OP_RLC) || (opQ == RRE_OP_RLN);
   assign destFile = instrQ[`RRE_FLD_D];
   assign popNow   = (phaseQ == RRE_Q4) && ((opQ == RRE_OP_RET) || (opQ == RRE_OP_LRET));

   // ----------------------------------------
   // File register access
   // ----------------------------------------
   always_comb
   begin
      if (instrQ[`RRE_FLD_A])
      begin
         fileAddr = {bankQ, instrQ[7:0]};
      end
      else if (instrQ[7:0] < `RRE_ACC_SPLIT)
      begin
         fileAddr = {4'h0, instrQ[7:0]};
      end
      else
      begin
         fileAddr = {`RRE_ACC_HIBANK, instrQ[7:0]};
      end
   end

   assign fileRd     = isRot && (phaseQ == RRE_Q2);
   assign fileWr     = isRot && (phaseQ == RRE_Q4) && destFile;
   assign fileWrData = resultQ;

   // Process in Q3 on the data read in Q2
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         resultQ   <= `RRE_RST_BYTE;
         carryOutQ <= 1'b0;
      end
      else if (isRot && (phaseQ == RRE_Q3))
      begin
         carryOutQ <= fileRdData[7];
         if (opQ == RRE_OP_RLC)
         begin
            resultQ <= {fileRdData[6:0], flagsQ[`RRE_ST_C]};
         end
         else
         begin
            resultQ <= {fileRdData[6:0], fileRdData[7]};
         end
      end
   end

   // ----------------------------------------
   // Working, flags and bank registers
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         workQ  <= `RRE_RST_BYTE;
         flagsQ <= `RRE_RST_BYTE;
         bankQ  <= 4'h0;
      end
      else if (popNow && (opQ == RRE_OP_LRET))
      begin
         workQ <= instrQ[7:0];
      end
      else if (popNow && instrQ[`RRE_FLD_S])
      begin
         workQ  <= workShadQ;
         flagsQ <= flagsShadQ;
         bankQ  <= bankShadQ;
      end
      else if (popNow)
      begin
         workQ <= workQ;
      end
      else if (isRot && (phaseQ == RRE_Q4))
      begin
         if (!destFile)
         begin
            workQ <= resultQ;
         end
         flagsQ[`RRE_ST_N] <= resultQ[7];
         flagsQ[`RRE_ST_Z] <= (resultQ == 8'h00);
         if (opQ == RRE_OP_RLC)
         begin
            flagsQ[`RRE_ST_C] <= carryOutQ;
         end
      end
      else if (regWr && (regAddr == `RRE_REG_WORK))
      begin
         workQ <= regWrData;
      end
      else if (regWr && (regAddr == `RRE_REG_FLAGS))
      begin
         flagsQ <= regWrData;
      end
      else if (regWr && (regAddr == `RRE_REG_BANK))
      begin
         bankQ <= regWrData[3:0];
      end
   end

   // Shadows and upper latches change only from the port
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         workShadQ  <= `RRE_RST_BYTE;
         flagsShadQ <= `RRE_RST_BYTE;
         bankShadQ  <= 4'h0;
         pcHighQ    <= `RRE_RST_BYTE;
         pcUpQ      <= `RRE_RST_BYTE;
      end
      else if (regWr)
      begin
         if (regAddr == `RRE_REG_WSHAD)
         begin
            workShadQ <= regWrData;
         end
         else if (regAddr == `RRE_REG_FSHAD)
         begin
            flagsShadQ <= regWrData;
         end
         else if (regAddr == `RRE_REG_BSHAD)
         begin
            bankShadQ <= regWrData[3:0];
         end
         else if (regAddr == `RRE_REG_PCHI)
         begin
            pcHighQ <= regWrData;
         end
         else if (regAddr == `RRE_REG_PCUP)
         begin
            pcUpQ <= regWrData;
         end
      end
   end

   // ----------------------------------------
   // Return stack and program counter
   // ----------------------------------------
   // Read the entry below the pointer so the top is ready by Q4
   assign topAddr = (spQ == '0) ? '0 : SPW'(spQ - 1'b1);

   rre_stack_mem #(
      .WIDTH (PCW),
      .DEPTH (DEPTH),
      .AW    (SPW)
   ) u_stack (
      .mclk   (mclk),
      .wrEn   (pushReq && !popNow && (spQ != SPW'(DEPTH))),
      .wrAddr (spQ),
      .wrData (pushAddr),
      .rdAddr (topAddr),
      .rdData (stackTop)
   );

   // Empty pop keeps pointer at zero; full push is dropped
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         spQ <= '0;
      end
      else if (popNow)
      begin
         if (spQ != '0)
         begin
            spQ <= SPW'(spQ - 1'b1);
         end
      end
      else if (pushReq && (spQ != SPW'(DEPTH)))
      begin
         spQ <= SPW'(spQ + 1'b1);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         pcQ      <= `RRE_RST_PC;
         pcLoad_q <= 1'b0;
      end
      else
      begin
         pcLoad_q <= popNow;
         if (popNow)
         begin
            pcQ <= stackTop;
         end
      end
   end

   // ----------------------------------------
   // Register port read
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         regRdData <= `RRE_RST_BYTE;
      end
      else if (regRd)
      begin
         if (regAddr == `RRE_REG_WORK)
            regRdData <= workQ;
         else if (regAddr == `RRE_REG_FLAGS)
            regRdData <= flagsQ;
         else if (regAddr == `RRE_REG_BANK)
            regRdData <= {4'h0, bankQ};
         else if (regAddr == `RRE_REG_WSHAD)
            regRdData <= workShadQ;
         else if (regAddr == `RRE_REG_FSHAD)
            regRdData <= flagsShadQ;
         else if (regAddr == `RRE_REG_BSHAD)
            regRdData <= {4'h0, bankShadQ};
         else if (regAddr == `RRE_REG_PCHI)
            regRdData <= pcHighQ;
         else if (regAddr == `RRE_REG_PCUP)
            regRdData <= pcUpQ;
         else if (regAddr == `RRE_REG_PC0)
            regRdData <= pcQ[7:0];
         else if (regAddr == `RRE_REG_PC1)
            regRdData <= pcQ[15:8];
         else if (regAddr == `RRE_REG_PC2)
            regRdData <= {3'h0, pcQ[20:16]};
         else if (regAddr == `RRE_REG_SP)
            regRdData <= {3'h0, spQ};
         else
            regRdData <= `RRE_RST_BYTE;
      end
      else
      begin
         regRdData <= `RRE_RST_BYTE;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_ret_decode;
      @(posedge mclk) disable iff (!rst_b)
      (instrTake && ((instrWord & 16'hfffe) == 16'h0012)) |=> (opQ == RRE_OP_RET);
   endproperty
   a_ret_decode: assert property (p_ret_decode) else $error("return not decoded");

   property p_ret_pop;
      @(posedge mclk) disable iff (!rst_b)
      (popNow && (opQ == RRE_OP_RET)) |=> (pcQ == $past(stackTop)) && pcLoad_q;
   endproperty
   a_ret_pop: assert property (p_ret_pop) else $error("pc not loaded from stack top");

   property p_ret_shadow;
      @(posedge mclk) disable iff (!rst_b)
      (popNow && (opQ == RRE_OP_RET) && instrQ[0])
         |=> (workQ == $past(workShadQ)) && (flagsQ == $past(flagsShadQ)) && (bankQ == $past(bankShadQ));
   endproperty
   a_ret_shadow: assert property (p_ret_shadow) else $error("shadow restore missing");

   property p_ret_keep;
      @(posedge mclk) disable iff (!rst_b)
      (popNow && (opQ == RRE_OP_RET) && !instrQ[0]) |=> $stable(workQ) && $stable(flagsQ) && $stable(bankQ);
   endproperty
   a_ret_keep: assert property (p_ret_keep) else $error("return changed live registers");

   property p_ret_latch;
      @(posedge mclk) disable iff (!rst_b)
      (popNow && !regWr) |=> $stable(pcHighQ) && $stable(pcUpQ);
   endproperty
   a_ret_latch: assert property (p_ret_latch) else $error("upper latch changed on return");

   property p_two_cycle;
      @(posedge mclk) disable iff (!rst_b)
      popNow |=> (!instrTake && !fileRd && !popNow) [*4];
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("second cycle not idle");

   property p_rlc_carry;
      @(posedge mclk) disable iff (!rst_b)
      (fileRd && (opQ == RRE_OP_RLC)) ##1 1'b1 |=> ##1 (flagsQ[0] == $past(fileRdData[7], 2));
   endproperty
   a_rlc_carry: assert property (p_rlc_carry) else $error("carry not old bit 7");

   property p_rln_carry;
      @(posedge mclk) disable iff (!rst_b)
      (isRot && (opQ == RRE_OP_RLN) && (phaseQ == RRE_Q4) && !regWr) |=> $stable(flagsQ[0]);
   endproperty
   a_rln_carry: assert property (p_rln_carry) else $error("carry changed without carry");

   property p_rot_dest;
      @(posedge mclk) disable iff (!rst_b)
      (isRot && (phaseQ == RRE_Q4) && !destFile) |-> !fileWr ##1 (workQ == $past(resultQ));
   endproperty
   a_rot_dest: assert property (p_rot_dest) else $error("work destination wrong");

   property p_rot_phase;
      @(posedge mclk) disable iff (!rst_b)
      fileRd |-> ##2 (phaseQ == RRE_Q4) && (fileWr == destFile);
   endproperty
   a_rot_phase: assert property (p_rot_phase) else $error("rotate phases wrong");

endmodule : rre_core

// File: test/rre_file_model.sv
// Purpose: Banked data file on the far side of the rotate datapath
// Assumes: Read data are wanted in the cycle after fileRd and only there
// Notes:   Outside that cycle the bus shows the inverse of its last value
`timescale 1ns/1ns
module rre_file_model (
   // Clock
   input  wire logic               mclk,
   // File port
   input  wire logic [11:0]        fileAddr,
   input  wire logic               fileRd,
   output rre_pkg::rre_byte_t      fileRdData,
   input  wire logic               fileWr,
   input  wire rre_pkg::rre_byte_t fileWrData
);
   import rre_pkg::*;
   rre_byte_t mem [4096];
   rre_byte_t rdByte_q = 8'h00;
   logic      rdValid_q = 1'b0;

   always @(posedge mclk)
   begin
      if (fileWr)
         mem[fileAddr] <= fileWrData;
      rdValid_q <= fileRd;
      if (fileRd)
         rdByte_q <= mem[fileAddr];
   end

   // Stale data must never look valid to a late sampler
   assign fileRdData = rdValid_q ? rdByte_q : ~rdByte_q;

   function automatic void poke(input logic [11:0] a, input rre_byte_t v);
      mem[a] = v;
   endfunction : poke

   function automatic rre_byte_t peek(input logic [11:0] a);
      return mem[a];
   endfunction : peek
endmodule : rre_file_model

// File: test/tb_return_and_rotate_exec.sv
// Purpose: Self-checking bench for the return and rotate executor
// Assumes: Bench fetches instructions and pushes return addresses itself
// Notes:   Take spacing and counter loads are timed by a cycle count
`timescale 1ns/1ns
module tb_return_and_rotate_exec;
   import rre_pkg::*;
   logic             mclk = 1'b0;
   logic             rst_b = 1'b0;
   logic [15:0]      instrWord = 16'h0000;
   logic             instrValid = 1'b0;
   logic             instrTake;
   logic             pushReq = 1'b0;
   logic [20:0]      pushAddr = 21'h000000;
   logic [20:0]      pcQ;
   logic             pcLoad_q;
   logic [11:0]      fileAddr;
   logic             fileRd;
   rre_byte_t        fileRdData;
   logic             fileWr;
   rre_byte_t        fileWrData;
   logic [3:0]       regAddr = 4'h0;
   rre_byte_t        regWrData = 8'h00;
   logic             regWr = 1'b0;
   logic             regRd = 1'b0;
   rre_byte_t        regRdData;
   int               fails = 0;
   int               checks = 0;
   int               cyc = 0;
   int               takeCyc = 0;
   int               gap = 0;
   int               loadCyc [$];
   logic [20:0]      loadPc [$];
   rre_byte_t        v;

   rre_core i_dut (.mclk(mclk), .rst_b(rst_b), .instrWord(instrWord), .instrValid(instrValid),
      .instrTake(instrTake), .pushReq(pushReq), .pushAddr(pushAddr), .pcQ(pcQ), .pcLoad_q(pcLoad_q),
      .fileAddr(fileAddr), .fileRd(fileRd), .fileRdData(fileRdData), .fileWr(fileWr),
      .fileWrData(fileWrData), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData));
   rre_file_model i_mem (.mclk(mclk), .fileAddr(fileAddr), .fileRd(fileRd), .fileRdData(fileRdData),
      .fileWr(fileWr), .fileWrData(fileWrData));

   initial
   begin
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk)
      cyc <= cyc + 1;

   always @(negedge mclk)
   begin
      if (pcLoad_q === 1'b1)
      begin
         loadCyc.push_back(cyc);
         loadPc.push_back(pcQ);
      end
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // An edge passes after the strobe drops so a following call never re-raises it in the same step
   task automatic regWrite(input logic [3:0] a, input rre_byte_t d);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
      @(posedge mclk);
   endtask : regWrite

   task automatic regRead(input logic [3:0] a, output rre_byte_t d);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      d = regRdData;
      @(posedge mclk);
   endtask : regRead

   task automatic expectReg(input logic [3:0] a, input rre_byte_t exp);
      rre_byte_t d;
      regRead(a, d);
      check({16'h0000, d}, {16'h0000, exp});
   endtask : expectReg

   task automatic push(input logic [20:0] a);
      pushReq  <= 1'b1;
      pushAddr <= a;
      @(posedge mclk);
      pushReq <= 1'b0;
      @(posedge mclk);
   endtask : push

   // Valid stays up so a following call keeps the pipe full
   task automatic exec(input logic [15:0] w);
      int prev;
      prev = takeCyc;
      instrWord  <= w;
      instrValid <= 1'b1;
      for (int i = 0; i < 20; i++)
      begin
         @(negedge mclk);
         if (instrTake === 1'b1)
            break;
      end
      @(posedge mclk);
      #1;
      takeCyc = cyc;
      gap     = takeCyc - prev;
   endtask : exec

   task automatic idle;
      instrValid <= 1'b0;
      repeat (10) @(posedge mclk);
   endtask : idle

   function automatic logic [15:0] rot(input logic [15:0] base, input logic d, input logic a,
                                       input rre_byte_t f);
      return base | {6'h00, d, a, f};
   endfunction : rot

   task automatic give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (20000) @(posedge mclk);
      fails++;
      give_verdict;
   end

   initial
   begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 16; i++)
         expectReg(i[3:0], 8'h00);
      $display("test reset done");

      // Access bank must ignore the bank select register
      i_mem.poke(12'h010, 8'he6);
      i_mem.poke(12'h310, 8'h77);
      regWrite(4'h1, 8'h00);
      regWrite(4'h2, 8'h03);
      exec(rot(16'h3400, 1'b1, 1'b0, 8'h10));
      idle;
      check({16'h0000, i_mem.peek(12'h010)}, 24'h0000cc);
      check({16'h0000, i_mem.peek(12'h310)}, 24'h000077);
      expectReg(4'h1, 8'h11);
      i_mem.poke(12'h320, 8'h80);
      regWrite(4'h1, 8'h01);
      exec(rot(16'h3400, 1'b0, 1'b1, 8'h20));
      idle;
      expectReg(4'h0, 8'h01);
      expectReg(4'h1, 8'h01);
      check({16'h0000, i_mem.peek(12'h320)}, 24'h000080);
      $display("test rotate carry done");

      i_mem.poke(12'hf90, 8'h80);
      i_mem.poke(12'h011, 8'hab);
      regWrite(4'h1, 8'h00);
      exec(rot(16'h3400, 1'b1, 1'b0, 8'h90));
      exec(rot(16'h4400, 1'b1, 1'b0, 8'h11));
      check(gap, 24'h000004);
      idle;
      check({16'h0000, i_mem.peek(12'hf90)}, 24'h000000);
      check({16'h0000, i_mem.peek(12'h011)}, 24'h000057);
      expectReg(4'h1, 8'h01);
      $display("test back to back rotates done");

      regWrite(4'h0, 8'h11);
      regWrite(4'h1, 8'h14);
      regWrite(4'h2, 8'h02);
      regWrite(4'h3, 8'h99);
      regWrite(4'h4, 8'h01);
      regWrite(4'h5, 8'h05);
      regWrite(4'h6, 8'h55);
      regWrite(4'h7, 8'h1a);
      push(21'h012345);
      push(21'h0abcde);
      loadCyc.delete();
      loadPc.delete();
      exec(16'h0012);
      exec(16'h0c5a);
      check(gap, 24'h000008);
      idle;
      check(loadCyc.size(), 24'h000002);
      check(loadCyc[0] + 8 - takeCyc, 24'h000003);
      check({3'h0, loadPc[0]}, 24'h0abcde);
      check({3'h0, loadPc[1]}, 24'h012345);
      expectReg(4'h0, 8'h5a);
      expectReg(4'h1, 8'h14);
      expectReg(4'h2, 8'h02);
      expectReg(4'h6, 8'h55);
      expectReg(4'h7, 8'h1a);
      $display("test plain return done");

      push(21'h1fffff);
      exec(16'h0014);
      idle;
      check(loadCyc.size(), 24'h000002);
      exec(16'h0013);
      idle;
      check({3'h0, pcQ}, 24'h1fffff);
      expectReg(4'h0, 8'h99);
      expectReg(4'h1, 8'h01);
      expectReg(4'h2, 8'h05);
      expectReg(4'h8, 8'hff);
      expectReg(4'ha, 8'h1f);
      expectReg(4'h7, 8'h1a);
      $display("test shadow return done");
      give_verdict;
   end
endmodule : tb_return_and_rotate_exec
